/* File: iev_cfg.svh */
`ifndef IEV_CFG_SVH
`define IEV_CFG_SVH

// source count and vector addresses
`define IEV_NSRC        18
`define IEV_RESET_VEC   16'h0000
`define IEV_VEC_BASE    16'h0003
`define IEV_VEC_STEP    16'h0008
`define IEV_LANE_BITS   8

// register indices; byte address is four times the index
`define IEV_IDX_XEN_ONE 8'h9b
`define IEV_IDX_XEN_TWO 8'h9c
`define IEV_IDX_PEN     8'ha8
`define IEV_IDX_PRIO_LO 8'hc0
`define IEV_IDX_PRIO_HI 8'hc1
`define IEV_IDX_SOFT    8'hc2
`define IEV_IDX_PEND    8'hc3
`define IEV_IDX_INSVC   8'hc4

// reset values and writable masks
`define IEV_EN_RESET    8'h00
`define IEV_XEN_ONE_WR  8'hbf
`define IEV_XEN_TWO_WR  8'h07

// vector numbers of the sources
`define IEV_V_EXT0      0
`define IEV_V_TMR0      1
`define IEV_V_EXT1      2
`define IEV_V_TMR1      3
`define IEV_V_UART0     4
`define IEV_V_T2A       5
`define IEV_V_I2C       6
`define IEV_V_PIN       7
`define IEV_V_BOD       8
`define IEV_V_SPARE     9
`define IEV_V_WDT       10
`define IEV_V_ADC       11
`define IEV_V_T2B       12
`define IEV_V_T2C       13
`define IEV_V_T2D       14
`define IEV_V_UART1     15
`define IEV_V_TMR3      16
`define IEV_V_WKT       17

// timer-2 control flag positions, channels a to d
`define IEV_T2_A_BIT    4
`define IEV_T2_B_BIT    5
`define IEV_T2_C_BIT    6
`define IEV_T2_D_BIT    7

// natural order, first entry in the low bits wins ties
`define IEV_NAT_ORDER {5'h11, 5'h10, 5'h0f, 5'h0e, 5'h0d, 5'h0c, 5'h09, 5'h05, 5'h04, \
                       5'h03, 5'h07, 5'h02, 5'h0b, 5'h06, 5'h01, 5'h0a, 5'h08, 5'h00}

`endif

/* File: iev_pkg.sv */
`default_nettype none
package iev_pkg;
    typedef logic [1:0]  iev_lvl_t;
    typedef logic [4:0]  iev_vidx_t;
    typedef logic [15:0] iev_addr_t;
endpackage
`default_nettype wire

/* File: iev_arbiter.sv */
`timescale 1ns/1ns
`default_nettype none
`include "iev_cfg.svh"

module iev_arbiter #(
    parameter int NSRC = `IEV_NSRC
) (
    input  wire logic [NSRC-1:0] req_i,
    input  wire logic [NSRC-1:0] prio_low_i,
    input  wire logic [NSRC-1:0] prio_high_i,
    output logic                 any_o,
    output iev_pkg::iev_vidx_t   idx_o,
    output iev_pkg::iev_lvl_t    lvl_o
);
    import iev_pkg::*;

    localparam logic [5*NSRC-1:0] ORDER = `IEV_NAT_ORDER;

    // walk the natural order; only a strictly higher level displaces
    // the current pick, so the earlier source wins a tie
    always_comb begin
        iev_vidx_t src;
        iev_lvl_t  lvl;
        src   = '0;
        lvl   = '0;
        any_o = 1'b0;
        idx_o = '0;
        lvl_o = '0;
        for (int k = 0; k < NSRC; k++) begin
            src = ORDER[5*k +: 5];
            lvl = {prio_high_i[src], prio_low_i[src]};
            if (req_i[src] && (!any_o || lvl > lvl_o)) begin // RULE20
                any_o = 1'b1;
                idx_o = src;
                lvl_o = lvl;
            end
        end
    end

endmodule
`default_nettype wire

/* File: iev_top.sv */
// Implementation choice: register access over Wishbone.
`timescale 1ns/1ns
`default_nettype none
`include "iev_cfg.svh"

// Contract
// RULE1: eighteen sources, four levels, each with own level, vector and enable
// RULE2: a running routine yields only to a strictly higher level
// RULE3: return pulse leaves the in-service state of the current level (a return in the same cycle as a take is ignored)
// RULE4: vector 0003h for number 0, step eight up to 008bh; reset 0000h
// RULE5: global enable at primary bit 7 low blocks every source
// RULE6: requests during global disable stay pending and are served later
// RULE7: software-set flags request exactly like hardware-set ones
// RULE8: an enabled source requests whenever its flag is one
// RULE9: service software clears its flags to avoid repeated requests
// RULE10: each source is gated by its own enable bit
// RULE11: primary enable holds global, adc, brownout, uart0, timer1, ext1, timer0, ext0
// RULE12: first extended enable holds t2d, t2c, watchdog, t2b, t2a, pin, i2c
// RULE13: second extended enable holds wakeup timer, timer3, uart1
// RULE14: uart0 request is tx-done or rx-done, gated by its enable
// RULE15: i2c request is state-change or timeout, gated by one enable
// RULE16: pin request is any of eight channel flags when enabled
// RULE17: uart1 request is tx-done or rx-done, gated by its enable
// RULE18: timer-2 channels a to d flags are control bits 4 to 7
// RULE19: same or lower level requests wait for the active return
// RULE20: ties at one level resolve by fixed natural order
// RULE21: edge-triggered external flags clear when their routine is entered
// RULE22: request and vector to core; core acks fetch and pulses return
module iev_top (
    input  wire logic         ref_clk_i,
    input  wire logic         resetn_i,
    input  wire logic         wb_cyc_i,
    input  wire logic         wb_stb_i,
    input  wire logic         wb_we_i,
    input  wire logic [9:0]   wb_adr_i,
    input  wire logic [3:0]   wb_sel_i,
    input  wire logic [31:0]  wb_dat_i,
    output logic      [31:0]  wb_dat_o,
    output logic              wb_ack_o,
    input  wire logic         adc_flag_i,
    input  wire logic         brownout_flag_i,
    input  wire logic         watchdog_flag_i,
    input  wire logic         timer0_flag_i,
    input  wire logic         timer1_flag_i,
    input  wire logic         timer3_flag_i,
    input  wire logic         wakeup_timer_flag_i,
    input  wire logic         uart0_tx_done_flag_i,
    input  wire logic         uart0_rx_done_flag_i,
    input  wire logic         uart1_tx_done_flag_i,
    input  wire logic         uart1_rx_done_flag_i,
    input  wire logic         i2c_state_flag_i,
    input  wire logic         i2c_timeout_flag_i,
    input  wire logic [7:0]   pin_change_flags_i,
    input  wire logic [7:0]   timer2_control_i,
    input  wire logic [1:0]   ext_pin_n_i,
    input  wire logic [1:0]   ext_pin_trigger_type_i,
    output logic              irq_req_o,
    output iev_pkg::iev_addr_t irq_vector_o,
    output iev_pkg::iev_lvl_t irq_level_o,
    input  wire logic         irq_ack_i,
    input  wire logic         reti_i
);
    import iev_pkg::*;

    localparam int NSRC = `IEV_NSRC;

    logic [7:0]      primary_irq_enable;
    logic [7:0]      extended_irq_enable_one;
    logic [7:0]      extended_irq_enable_two;
    logic [NSRC-1:0] prio_low;
    logic [NSRC-1:0] prio_high;
    logic [NSRC-1:0] soft_flag;
    logic [NSRC-1:0] hw_flag;
    logic [NSRC-1:0] src_flag;
    logic [NSRC-1:0] src_en;
    logic [NSRC-1:0] src_req;
    logic [3:0]      in_service;
    logic [1:0]      ext_pin_flag;
    logic [1:0]      pin_meta;
    logic [1:0]      pin_sync;
    logic [1:0]      pin_prev;
    logic [1:0]      pin_fall;
    logic [1:0]      ext_taken;
    logic            win_any;
    iev_vidx_t       win_idx;
    iev_lvl_t        win_lvl;
    iev_vidx_t       req_idx;
    logic            preempt_ok;
    logic            next_req;
    logic            taken;
    logic            bus_req;
    logic            bus_wr;
    logic [7:0]      bus_idx;
    logic [31:0]     rd_val;

    // named enable bits
    logic global_irq_enable;
    logic adc_irq_enable;
    logic brownout_irq_enable;
    logic uart0_irq_enable;
    logic timer1_irq_enable;
    logic ext_pin1_irq_enable;
    logic timer0_irq_enable;
    logic ext_pin0_irq_enable;
    logic timer2_chan_d_irq_enable;
    logic timer2_chan_c_irq_enable;
    logic watchdog_irq_enable;
    logic timer2_chan_b_irq_enable;
    logic timer2_chan_a_irq_enable;
    logic pin_change_irq_enable;
    logic i2c_irq_enable;
    logic wakeup_timer_irq_enable;
    logic timer3_irq_enable;
    logic uart1_irq_enable;

    // highest level currently in service
    function automatic iev_lvl_t top_level(input logic [3:0] svc);
        iev_lvl_t r;
        r = '0;
        for (int l = 0; l < 4; l++) begin
            if (svc[l]) begin
                r = iev_lvl_t'(l);
            end
        end
        return r;
    endfunction

    // byte-lane merge for the wide registers
    function automatic logic [NSRC-1:0] lane_write(input logic [NSRC-1:0] old_v,
                                                   input logic [31:0] wd,
                                                   input logic [3:0] sel);
        logic [NSRC-1:0] r;
        r = old_v;
        for (int b = 0; b < NSRC; b++) begin
            if (sel[b / `IEV_LANE_BITS]) begin
                r[b] = wd[b];
            end
        end
        return r;
    endfunction

    // enable bit positions in the three enable registers
    assign global_irq_enable        = primary_irq_enable[7];       // RULE11
    assign adc_irq_enable           = primary_irq_enable[6];
    assign brownout_irq_enable      = primary_irq_enable[5];
    assign uart0_irq_enable         = primary_irq_enable[4];
    assign timer1_irq_enable        = primary_irq_enable[3];
    assign ext_pin1_irq_enable      = primary_irq_enable[2];
    assign timer0_irq_enable        = primary_irq_enable[1];
    assign ext_pin0_irq_enable      = primary_irq_enable[0];
    assign timer2_chan_d_irq_enable = extended_irq_enable_one[7];  // RULE12
    assign timer2_chan_c_irq_enable = extended_irq_enable_one[5];
    assign watchdog_irq_enable      = extended_irq_enable_one[4];
    assign timer2_chan_b_irq_enable = extended_irq_enable_one[3];
    assign timer2_chan_a_irq_enable = extended_irq_enable_one[2];
    assign pin_change_irq_enable    = extended_irq_enable_one[1];
    assign i2c_irq_enable           = extended_irq_enable_one[0];
    assign wakeup_timer_irq_enable  = extended_irq_enable_two[2];  // RULE13
    assign timer3_irq_enable        = extended_irq_enable_two[1];
    assign uart1_irq_enable         = extended_irq_enable_two[0];

    // enables by vector number; the spare slot never requests
    always_comb begin
        src_en                = '0;
        src_en[`IEV_V_EXT0]   = ext_pin0_irq_enable;
        src_en[`IEV_V_TMR0]   = timer0_irq_enable;
        src_en[`IEV_V_EXT1]   = ext_pin1_irq_enable;
        src_en[`IEV_V_TMR1]   = timer1_irq_enable;
        src_en[`IEV_V_UART0]  = uart0_irq_enable;
        src_en[`IEV_V_T2A]    = timer2_chan_a_irq_enable;
        src_en[`IEV_V_I2C]    = i2c_irq_enable;
        src_en[`IEV_V_PIN]    = pin_change_irq_enable;
        src_en[`IEV_V_BOD]    = brownout_irq_enable;
        src_en[`IEV_V_WDT]    = watchdog_irq_enable;
        src_en[`IEV_V_ADC]    = adc_irq_enable;
        src_en[`IEV_V_T2B]    = timer2_chan_b_irq_enable;
        src_en[`IEV_V_T2C]    = timer2_chan_c_irq_enable;
        src_en[`IEV_V_T2D]    = timer2_chan_d_irq_enable;
        src_en[`IEV_V_UART1]  = uart1_irq_enable;
        src_en[`IEV_V_TMR3]   = timer3_irq_enable;
        src_en[`IEV_V_WKT]    = wakeup_timer_irq_enable;
    end

    // hardware flags by vector number; composite sources are ored
    always_comb begin
        hw_flag               = '0;
        hw_flag[`IEV_V_EXT0]  = ext_pin_flag[0];
        hw_flag[`IEV_V_TMR0]  = timer0_flag_i;
        hw_flag[`IEV_V_EXT1]  = ext_pin_flag[1];
        hw_flag[`IEV_V_TMR1]  = timer1_flag_i;
        hw_flag[`IEV_V_UART0] = uart0_tx_done_flag_i | uart0_rx_done_flag_i; // RULE14
        hw_flag[`IEV_V_T2A]   = timer2_control_i[`IEV_T2_A_BIT];              // RULE18
        hw_flag[`IEV_V_I2C]   = i2c_state_flag_i | i2c_timeout_flag_i;        // RULE15
        hw_flag[`IEV_V_PIN]   = |pin_change_flags_i;                          // RULE16
        hw_flag[`IEV_V_BOD]   = brownout_flag_i;
        hw_flag[`IEV_V_WDT]   = watchdog_flag_i;
        hw_flag[`IEV_V_ADC]   = adc_flag_i;
        hw_flag[`IEV_V_T2B]   = timer2_control_i[`IEV_T2_B_BIT];              // RULE18
        hw_flag[`IEV_V_T2C]   = timer2_control_i[`IEV_T2_C_BIT];
        hw_flag[`IEV_V_T2D]   = timer2_control_i[`IEV_T2_D_BIT];
        hw_flag[`IEV_V_UART1] = uart1_tx_done_flag_i | uart1_rx_done_flag_i; // RULE17
        hw_flag[`IEV_V_TMR3]  = timer3_flag_i;
        hw_flag[`IEV_V_WKT]   = wakeup_timer_flag_i;
    end

    // a soft flag is a second source for the same request line
    assign src_flag = hw_flag | soft_flag;                                // RULE7
    // flags are never consumed by gating, so a blocked request waits
    assign src_req  = src_flag & src_en & {NSRC{global_irq_enable}};     // RULE5 RULE6 RULE8 RULE10

    iev_arbiter #(
        .NSRC        (NSRC)
    ) u_arbiter (
        .req_i       (src_req),
        .prio_low_i  (prio_low),
        .prio_high_i (prio_high),
        .any_o       (win_any),
        .idx_o       (win_idx),
        .lvl_o       (win_lvl)
    );                                                                    // RULE1 RULE20

    // only a strictly higher level may nest over what is in service
    assign preempt_ok = (in_service == 4'h0) || (win_lvl > top_level(in_service)); // RULE2 RULE19
    assign next_req   = win_any & preempt_ok;
    assign taken      = irq_ack_i & irq_req_o;

    // request and vector are registered; a take drops the request for a
    // cycle so in-service is updated before the next pick
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            irq_req_o    <= 1'b0;
            irq_vector_o <= `IEV_RESET_VEC;                               // RULE4
            irq_level_o  <= '0;
            req_idx      <= '0;
        end else if (taken) begin
            irq_req_o    <= 1'b0;                                         // RULE22
        end else begin
            irq_req_o    <= next_req;
            irq_vector_o <= `IEV_VEC_BASE + 16'(win_idx) * `IEV_VEC_STEP; // RULE4
            irq_level_o  <= win_lvl;
            req_idx      <= win_idx;
        end
    end

    // in-service levels: a take marks, a return clears the top level; a take in the same cycle wins and that return is lost
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            in_service <= 4'h0;
        end else if (taken) begin
            in_service <= in_service | (4'h1 << irq_level_o);             // RULE22
        end else if (reti_i) begin
            in_service <= in_service & ~(4'h1 << top_level(in_service));  // RULE3
        end
    end

    // external pins cross into this clock through two flops
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            pin_meta <= 2'h3;
            pin_sync <= 2'h3;
            pin_prev <= 2'h3;
        end else begin
            pin_meta <= ext_pin_n_i;
            pin_sync <= pin_meta;
            pin_prev <= pin_sync;
        end
    end

    assign pin_fall     = pin_prev & ~pin_sync;
    assign ext_taken[0] = taken && (req_idx == iev_vidx_t'(`IEV_V_EXT0));
    assign ext_taken[1] = taken && (req_idx == iev_vidx_t'(`IEV_V_EXT1));

    // level mode follows the inverted pin; edge mode latches a fall and
    // a new fall in the take cycle wins over the clear
    for (genvar p = 0; p < 2; p++) begin : g_ext
        always_ff @(posedge ref_clk_i or negedge resetn_i) begin
            if (!resetn_i) begin
                ext_pin_flag[p] <= 1'b0;
            end else if (!ext_pin_trigger_type_i[p]) begin
                ext_pin_flag[p] <= ~pin_sync[p];
            end else if (pin_fall[p]) begin
                ext_pin_flag[p] <= 1'b1;
            end else if (ext_taken[p]) begin
                ext_pin_flag[p] <= 1'b0;                                  // RULE21
            end
        end
    end

    // wishbone classic: ack one cycle after the strobe, writes land
    // on the ack edge so they coincide with the master's sampling
    assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign bus_wr  = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o;
    assign bus_idx = wb_adr_i[9:2];

    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= bus_req;
        end
    end

    // enable registers; reserved bits stay zero
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            primary_irq_enable      <= `IEV_EN_RESET;
            extended_irq_enable_one <= `IEV_EN_RESET;
            extended_irq_enable_two <= `IEV_EN_RESET;
        end else if (bus_wr && wb_sel_i[0]) begin
            if (bus_idx == `IEV_IDX_PEN) begin
                primary_irq_enable <= wb_dat_i[7:0];
            end
            if (bus_idx == `IEV_IDX_XEN_ONE) begin
                extended_irq_enable_one <= wb_dat_i[7:0] & `IEV_XEN_ONE_WR;
            end
            if (bus_idx == `IEV_IDX_XEN_TWO) begin
                extended_irq_enable_two <= wb_dat_i[7:0] & `IEV_XEN_TWO_WR;
            end
        end
    end

    // priority and software flag registers
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            prio_low  <= '0;
            prio_high <= '0;
            soft_flag <= '0;
        end else if (bus_wr) begin
            if (bus_idx == `IEV_IDX_PRIO_LO) begin
                prio_low <= lane_write(prio_low, wb_dat_i, wb_sel_i);
            end
            if (bus_idx == `IEV_IDX_PRIO_HI) begin
                prio_high <= lane_write(prio_high, wb_dat_i, wb_sel_i);
            end
            if (bus_idx == `IEV_IDX_SOFT) begin
                soft_flag <= lane_write(soft_flag, wb_dat_i, wb_sel_i); // RULE7
            end
        end
    end

    // read mux; unmapped indices read zero and are still acked
    always_comb begin
        rd_val = 32'h0000_0000;
        case (bus_idx)
            `IEV_IDX_PEN:     rd_val = 32'(primary_irq_enable);
            `IEV_IDX_XEN_ONE: rd_val = 32'(extended_irq_enable_one);
            `IEV_IDX_XEN_TWO: rd_val = 32'(extended_irq_enable_two);
            `IEV_IDX_PRIO_LO: rd_val = 32'(prio_low);
            `IEV_IDX_PRIO_HI: rd_val = 32'(prio_high);
            `IEV_IDX_SOFT:    rd_val = 32'(soft_flag);
            `IEV_IDX_PEND:    rd_val = 32'(src_flag);
            `IEV_IDX_INSVC:   rd_val = 32'(in_service);
            default:          rd_val = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            wb_dat_o <= 32'h0000_0000;
        end else if (bus_req && !wb_we_i) begin
            wb_dat_o <= rd_val;
        end
    end

    // checks
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!resetn_i);

    a_global_block: assert property (!global_irq_enable |=> !irq_req_o) // RULE5
        else $error("request raised while globally disabled");
    a_vector_map: assert property (irq_req_o |->                       // RULE4
        irq_vector_o == `IEV_VEC_BASE + 16'(req_idx) * `IEV_VEC_STEP)
        else $error("vector does not match source number");
    a_preempt_level: assert property (irq_req_o && in_service != 4'h0 // RULE2
        |-> irq_level_o > top_level(in_service))
        else $error("request not above level in service");
    a_ack_service: assert property (taken |=>                          // RULE22
        in_service[$past(irq_level_o)] && !irq_req_o)
        else $error("take did not mark level in service");
    a_reti_clear: assert property (reti_i && !taken && in_service != 4'h0 // RULE3
        |=> in_service < $past(in_service))
        else $error("return did not leave top level");
    a_enable_gate: assert property (win_any |->                        // RULE10
        src_en[win_idx] && src_flag[win_idx] && global_irq_enable)
        else $error("winner not enabled or not flagged");
    a_pending_serve: assert property (!irq_req_o && win_any &&        // RULE6
        in_service == 4'h0 |=> irq_req_o ##0 irq_level_o == $past(win_lvl))
        else $error("pending request not presented");
    a_edge_clear: assert property (ext_taken[0] && ext_pin_trigger_type_i[0] // RULE21
        && !pin_fall[0] |=> !ext_pin_flag[0])
        else $error("edge flag not cleared on entry");

    c_nested: cover property (in_service[3] && in_service[0]);
    c_return: cover property (reti_i && in_service != 4'h0);
    c_ext_take: cover property (ext_taken[0] && ext_pin_trigger_type_i[0]);

endmodule
`default_nettype wire

/* File: iev_core_model.sv */
`timescale 1ns/1ns
`default_nettype none
// stand-in for the core: acks a presented vector after a set wait, returns on command
module iev_core_model (
    input  wire logic       clk_i,
    input  wire logic       resetn_i,
    input  wire logic       irq_req_i,
    input  wire logic [3:0] ack_wait_i,
    input  wire logic       ret_go_i,
    output logic            irq_ack_o,
    output logic            reti_o
);
    logic [3:0] wait_cnt;
    // one-cycle ack, only while a request stands; wait lets the bench act slow
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            irq_ack_o <= 1'b0;
            wait_cnt  <= 4'h0;
        end else if (irq_req_i && !irq_ack_o && wait_cnt >= ack_wait_i) begin
            irq_ack_o <= 1'b1;
            wait_cnt  <= 4'h0;
        end else begin
            irq_ack_o <= 1'b0;
            wait_cnt  <= irq_req_i ? wait_cnt + 4'h1 : 4'h0;
        end
    end
    // return pulse, one cycle long
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) reti_o <= 1'b0;
        else reti_o <= ret_go_i;
    end
endmodule
`default_nettype wire

/* File: tb_interrupt_enable_vectoring.sv */
`timescale 1ns/1ns
`default_nettype none
module tb_interrupt_enable_vectoring;
    logic clk, rstn, cyc, stb, we, ret_go, ack, req, ack_c, reti;
    logic [9:0] adr;
    logic [3:0] ack_wait;
    logic [31:0] wdat, rdat, q;
    logic [17:0] fl, fb;
    logic [1:0] trig;
    iev_pkg::iev_addr_t vec;
    iev_pkg::iev_lvl_t lvl, tl;
    int err_total, checks_done;
    iev_top dut (.ref_clk_i(clk), .resetn_i(rstn), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .adc_flag_i(fl[11]), .brownout_flag_i(fl[8]), .watchdog_flag_i(fl[10]), .timer0_flag_i(fl[1]),
        .timer1_flag_i(fl[3]), .timer3_flag_i(fl[16]), .wakeup_timer_flag_i(fl[17]),
        .uart0_tx_done_flag_i(fl[4]), .uart0_rx_done_flag_i(fb[4]), .uart1_tx_done_flag_i(fl[15]),
        .uart1_rx_done_flag_i(fb[15]), .i2c_state_flag_i(fl[6]), .i2c_timeout_flag_i(fb[6]),
        .pin_change_flags_i({fl[7], 6'h00, fb[7]}), .timer2_control_i({fl[14:12], fl[5], 4'h0}),
        .ext_pin_n_i(~{fl[2], fl[0]}), .ext_pin_trigger_type_i(trig), .irq_req_o(req),
        .irq_vector_o(vec), .irq_level_o(lvl), .irq_ack_i(ack_c), .reti_i(reti));
    iev_core_model core (.clk_i(clk), .resetn_i(rstn), .irq_req_i(req), .ack_wait_i(ack_wait),
        .ret_go_i(ret_go), .irq_ack_o(ack_c), .reti_o(reti));
    // clock and stimulus at time zero
    initial begin
        clk = 0;
        forever #5 clk = ~clk;
    end
    task complete_run;
        $display("checks_done %0d err_total %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task cmp(input string what, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", what, e, g);
        end
    endtask
    // classic single cycle; ack sampled at the rising edge, data taken and request released there
    task bus(input logic w, input logic [7:0] idx, input logic [31:0] d);
        int n;
        @(posedge clk);
        {cyc, stb, we, adr, wdat} <= {2'b11, w, idx, 2'b00, d};
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 20);
        if (ack !== 1'b1) begin err_total++; complete_run; end
        q = rdat;
        {cyc, stb} <= 2'b00;
    endtask
    task setf(input int n, input logic v, input logic alt);
        @(posedge clk);
        if (alt) fb[n] <= v;
        else fl[n] <= v;
    endtask
    // expects the vector, then waits for the core to take it
    task take(input logic [15:0] v);
        int n;
        n = 0;
        do begin @(negedge clk); n++; end while (req !== 1'b1 && n < 30);
        if (req !== 1'b1) begin err_total++; complete_run; end
        tl = lvl;
        cmp("vector", {16'h0, v}, {16'h0, vec});
        while (req !== 1'b0 && n < 60) begin @(negedge clk); n++; end
        if (req !== 1'b0) begin err_total++; complete_run; end
    endtask
    task quiet;
        int c;
        c = 0;
        repeat (8) begin @(negedge clk); if (req !== 1'b0) c++; end
        cmp("quiet", 0, c);
    endtask
    // routine body: caller clears the flag first; here five cycles of wait, then the return pulse
    task ret;
        repeat (5) @(posedge clk);
        ret_go <= 1'b1;
        @(posedge clk);
        ret_go <= 1'b0;
    endtask
    task t_regs;
        bus(0, 8'ha8, 0); cmp("pen", 0, q);
        bus(0, 8'h9b, 0); cmp("xen1", 0, q);
        bus(0, 8'h10, 0); cmp("unmapped", 0, q);
        bus(1, 8'h9b, 32'hff); bus(0, 8'h9b, 0); cmp("xen1 mask", 32'hbf, q);
        bus(1, 8'h9c, 32'hff); bus(0, 8'h9c, 0); cmp("xen2 mask", 32'h07, q);
        $display("test regs done");
    endtask
    task t_gate;
        bus(1, 8'ha8, 32'h02);
        setf(1, 1, 0); setf(11, 1, 0);
        quiet;
        bus(0, 8'hc3, 0); cmp("pending", 32'h802, q);
        bus(1, 8'ha8, 32'h82);
        take(16'h000b);
        setf(1, 0, 0); ret;
        quiet;
        setf(11, 0, 0);
        $display("test gate done");
    endtask
    task t_table;
        bus(1, 8'ha8, 32'hff);
        for (int n = 0; n < 18; n++) begin
            for (int a = 0; a < 2; a++) begin
                if (n == 9 || (a == 1 && !(n inside {4, 6, 7, 15}))) continue;
                setf(n, 1, a[0]);
                take(16'h0003 + 16'(8 * n));
                setf(n, 0, a[0]); ret;
            end
        end
        ack_wait <= 4'h3;
        bus(1, 8'hc2, 32'h8);
        take(16'h001b);
        bus(1, 8'hc2, 0); ret;
        $display("test table done");
    endtask
    task t_nest;
        bus(1, 8'hc0, 32'h502); bus(1, 8'hc1, 32'h100);
        setf(1, 1, 0); take(16'h000b); setf(1, 0, 0);
        setf(11, 1, 0); setf(10, 1, 0);
        quiet;
        setf(8, 1, 0); take(16'h0043); setf(8, 0, 0);
        cmp("level", 32'h3, {30'h0, tl});
        bus(0, 8'hc4, 0); cmp("in service", 32'ha, q);
        ret; quiet; ret;
        take(16'h0053); setf(10, 0, 0); ret;
        cmp("level", 32'h1, {30'h0, tl});
        take(16'h005b); setf(11, 0, 0); ret;
        bus(1, 8'hc0, 0); bus(1, 8'hc1, 0);
        bus(1, 8'hc2, 32'h402);
        take(16'h0053); bus(1, 8'hc2, 32'h2); ret;
        take(16'h000b); bus(1, 8'hc2, 0); ret;
        trig <= 2'b01;
        setf(0, 1, 0); setf(0, 0, 0);
        take(16'h0003); ret;
        quiet;
        $display("test nest done");
    endtask
    initial begin
        {rstn, cyc, stb, we, ret_go, adr, wdat, fl, fb, trig, ack_wait} = '0;
        err_total = 0;
        checks_done = 0;
        repeat (8) @(posedge clk);
        cmp("reset vec", 0, {16'h0, vec});
        rstn <= 1'b1;
        t_regs;
        t_gate;
        t_table;
        t_nest;
        complete_run;
    end
endmodule
`default_nettype wire
